// file: hdl/dpsf_pkg.sv
// Constants and types for the semaphore flag port controller
package dpsf_pkg;
  // ----------------------------------------------------------------
  // Geometry of the flag space on one port
  // ----------------------------------------------------------------
  localparam int          FLAG_COUNT  = 8;
  localparam int          INDEX_W     = 3;
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 16;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_FILL = 12'h000; // Upper address bits, ignored by flags
  localparam int          LOWEST_DATA_BIT = 0;            // lowest_data_line position

  // ----------------------------------------------------------------
  // Timing of one access on the pins
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          T_SETUP_NS    = 10;   // Address stable before select
  localparam int          T_ACCESS_NS   = 55;   // Select/output enable to valid data
  localparam int          T_WPULSE_NS   = 40;   // Write strobe width
  localparam int          T_GAP_NS      = 20;   // Select high between accesses
  localparam int          SYNC_STAGES   = 2;    // Input synchroniser depth

  // Least time in ns to whole cycles, never below one
  function automatic logic [7:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[7:0];
  endfunction

  localparam logic [7:0]  SETUP_CYC  = ns_to_cyc(T_SETUP_NS);
  localparam logic [7:0]  READ_CYC   = ns_to_cyc(T_ACCESS_NS) + 8'(SYNC_STAGES);
  localparam logic [7:0]  WRITE_CYC  = ns_to_cyc(T_WPULSE_NS);
  localparam logic [7:0]  GAP_CYC    = ns_to_cyc(T_GAP_NS);

  // ----------------------------------------------------------------
  // Claim policy and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  MAX_POLLS   = 8'h10;  // Extra reads after a failed claim
  localparam logic [FLAG_COUNT-1:0] OWNED_RST = 8'h00;

  // ----------------------------------------------------------------
  // Commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPSF_CMD_CLAIM   = 2'b00,
    DPSF_CMD_RELEASE = 2'b01,
    DPSF_CMD_INIT    = 2'b10
  } dpsf_cmd_t;

  typedef enum logic [2:0] {
    DPSF_ST_INIT     = 3'b000,
    DPSF_ST_IDLE     = 3'b001,
    DPSF_ST_CLAIM_WR = 3'b010,
    DPSF_ST_CLAIM_RD = 3'b011,
    DPSF_ST_WITHDRAW = 3'b100,
    DPSF_ST_RELEASE  = 3'b101
  } dpsf_state_t;

  typedef enum logic [1:0] {
    DPSF_E_IDLE   = 2'b00,
    DPSF_E_SETUP  = 2'b01,
    DPSF_E_STROBE = 2'b10,
    DPSF_E_GAP    = 2'b11
  } dpsf_eng_t;
endpackage

// file: hdl/dpsf_cyc_if.sv
// Request and answer path between sequencer and pin cycle engine
`timescale 1ns/1ps
interface dpsf_cyc_if;
  logic                        req_valid;  // One-cycle request pulse
  logic                        req_write;  // 1 write, 0 read
  logic [dpsf_pkg::INDEX_W-1:0] req_index;
  logic                        req_bit;    // Value written on the lowest data line
  logic                        done;       // One-cycle end-of-access pulse
  logic                        rd_bit;     // Flag value read, valid with done

  modport ctrl (output req_valid, output req_write, output req_index, output req_bit,
                input done, input rd_bit);
  modport engine (input req_valid, input req_write, input req_index, input req_bit,
                  output done, output rd_bit);
endinterface

// file: hdl/dpsf_pin_engine.sv
// Pin cycle engine: one semaphore read or write per request
`timescale 1ns/1ps
module dpsf_pin_engine (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  dpsf_cyc_if.engine                         cyc,
  input  wire logic [dpsf_pkg::DATA_W-1:0]   i_data_in,
  output logic                               o_flag_space_select_n,
  output logic                               o_oe_n,
  output logic                               o_rw_n,
  output logic [dpsf_pkg::ADDR_W-1:0]        o_addr,
  output logic [dpsf_pkg::DATA_W-1:0]        o_data_out,
  output logic                               o_data_oe
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dpsf_pkg::dpsf_eng_t              state_reg,  state_next;
  logic [7:0]                       cnt_reg,    cnt_next;
  logic                             write_reg,  write_next;
  logic                             sel_n_reg,  sel_n_next;
  logic                             oe_n_reg,   oe_n_next;
  logic                             rw_n_reg,   rw_n_next;
  logic [dpsf_pkg::ADDR_W-1:0]      addr_reg,   addr_next;
  logic [dpsf_pkg::DATA_W-1:0]      dout_reg,   dout_next;
  logic                             doe_reg,    doe_next;
  logic                             done_reg,   done_next;
  logic                             rbit_reg,   rbit_next;
  logic                             sync1_reg,  sync2_reg;

  // Lowest data line crosses in from the pins through two flops
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= i_data_in[dpsf_pkg::LOWEST_DATA_BIT];
      sync2_reg <= sync1_reg;
    end
  end

  // Access sequence: setup, strobe, gap with select released
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    write_next = write_reg;
    sel_n_next = sel_n_reg;
    oe_n_next  = oe_n_reg;
    rw_n_next  = rw_n_reg;
    addr_next  = addr_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    done_next  = 1'b0;
    rbit_next  = rbit_reg;
    case (state_reg)
      dpsf_pkg::DPSF_E_IDLE: begin
        if (cyc.req_valid) begin
          // Only the three low address bits pick the flag
          addr_next  = {dpsf_pkg::ADDR_HIGH_FILL[dpsf_pkg::ADDR_W-1:dpsf_pkg::INDEX_W],
                        cyc.req_index};
          // Request value goes on every line; the device samples the lowest
          dout_next  = {dpsf_pkg::DATA_W{cyc.req_bit}};
          write_next = cyc.req_write;
          doe_next   = cyc.req_write;
          cnt_next   = dpsf_pkg::SETUP_CYC - 8'h01;
          state_next = dpsf_pkg::DPSF_E_SETUP;
        end
      end
      dpsf_pkg::DPSF_E_SETUP: begin
        if (cnt_reg == 8'h00) begin
          // Select low, strobes used as for a plain static RAM
          sel_n_next = 1'b0;
          oe_n_next  = write_reg;
          rw_n_next  = ~write_reg;
          cnt_next   = (write_reg ? dpsf_pkg::WRITE_CYC : dpsf_pkg::READ_CYC) - 8'h01;
          state_next = dpsf_pkg::DPSF_E_STROBE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      dpsf_pkg::DPSF_E_STROBE: begin
        if (cnt_reg == 8'h00) begin
          if (!write_reg) begin
            rbit_next = sync2_reg;
          end
          // Select and output enable both go high so the next read relatches
          sel_n_next = 1'b1;
          oe_n_next  = 1'b1;
          rw_n_next  = 1'b1;
          cnt_next   = dpsf_pkg::GAP_CYC - 8'h01;
          state_next = dpsf_pkg::DPSF_E_GAP;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        doe_next = 1'b0;
        if (cnt_reg == 8'h00) begin
          done_next  = 1'b1;
          state_next = dpsf_pkg::DPSF_E_IDLE;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
    endcase
  end

  // Engine registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= dpsf_pkg::DPSF_E_IDLE;
      cnt_reg   <= 8'h00;
      write_reg <= 1'b0;
      sel_n_reg <= 1'b1;
      oe_n_reg  <= 1'b1;
      rw_n_reg  <= 1'b1;
      addr_reg  <= 12'h000;
      dout_reg  <= 16'hFFFF;
      doe_reg   <= 1'b0;
      done_reg  <= 1'b0;
      rbit_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      write_reg <= write_next;
      sel_n_reg <= sel_n_next;
      oe_n_reg  <= oe_n_next;
      rw_n_reg  <= rw_n_next;
      addr_reg  <= addr_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      done_reg  <= done_next;
      rbit_reg  <= rbit_next;
    end
  end

  assign cyc.done              = done_reg;
  assign cyc.rd_bit            = rbit_reg;
  assign o_flag_space_select_n = sel_n_reg;
  assign o_oe_n                = oe_n_reg;
  assign o_rw_n                = rw_n_reg;
  assign o_addr                = addr_reg;
  assign o_data_out            = dout_reg;
  assign o_data_oe             = doe_reg;
endmodule

// file: hdl/dpsf_host_ctrl.sv
// Host controller for one port of a dual-port semaphore flag set
`timescale 1ns/1ps
module dpsf_host_ctrl (
  input  wire logic                                i_core_clk,
  input  wire logic                                i_rst,
  input  wire logic                                i_cmd_valid,
  input  wire logic [1:0]                          i_cmd_op,
  input  wire logic [dpsf_pkg::INDEX_W-1:0]        i_cmd_index,
  output logic                                     o_cmd_ready,
  output logic                                     o_done,
  output logic                                     o_granted,
  output logic [dpsf_pkg::FLAG_COUNT-1:0]          o_owned,
  output logic                                     o_ram_ce_n,
  output logic                                     o_flag_space_select_n,
  output logic                                     o_oe_n,
  output logic                                     o_rw_n,
  output logic [dpsf_pkg::ADDR_W-1:0]              o_addr,
  output logic [dpsf_pkg::DATA_W-1:0]              o_data_out,
  output logic                                     o_data_oe,
  input  wire logic [dpsf_pkg::DATA_W-1:0]         i_data_in
);
  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  dpsf_pkg::dpsf_state_t                  state_reg,   state_next;
  logic [dpsf_pkg::INDEX_W-1:0]           idx_reg,     idx_next;
  logic [7:0]                             polls_reg,   polls_next;
  logic                                   req_reg,     req_next;
  logic                                   wr_reg,      wr_next;
  logic                                   bit_reg,     bit_next;
  logic                                   ready_reg,   ready_next;
  logic                                   done_reg,    done_next;
  logic                                   grant_reg,   grant_next;
  logic [dpsf_pkg::FLAG_COUNT-1:0]        owned_reg,   owned_next;
  logic                                   ce_n_reg;

  dpsf_cyc_if cyc ();

  // ----------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------
  dpsf_pin_engine u_engine (
    .i_core_clk            (i_core_clk),
    .i_rst                 (i_rst),
    .cyc                   (cyc.engine),
    .i_data_in             (i_data_in),
    .o_flag_space_select_n (o_flag_space_select_n),
    .o_oe_n                (o_oe_n),
    .o_rw_n                (o_rw_n),
    .o_addr                (o_addr),
    .o_data_out            (o_data_out),
    .o_data_oe             (o_data_oe)
  );

  // ----------------------------------------------------------------
  // Requests to the engine, all from registers
  // ----------------------------------------------------------------
  assign cyc.req_valid = req_reg;
  assign cyc.req_write = wr_reg;
  assign cyc.req_index = idx_reg;
  assign cyc.req_bit   = bit_reg;

  // ----------------------------------------------------------------
  // RAM array select
  // ----------------------------------------------------------------
  // RAM array never selected from this port
  always_ff @(posedge i_core_clk) begin
    ce_n_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  // Claim, release and initialisation sequencing
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    polls_next = polls_reg;
    req_next   = 1'b0;
    wr_next    = wr_reg;
    bit_next   = bit_reg;
    ready_next = ready_reg;
    done_next  = 1'b0;
    grant_next = grant_reg;
    owned_next = owned_reg;
    case (state_reg)
      dpsf_pkg::DPSF_ST_INIT: begin
        // Write one to each flag in turn to clear stale request latches
        if (cyc.done) begin
          owned_next[idx_reg] = 1'b0;
          // Last flag written: report and start taking commands
          if (idx_reg == 3'(dpsf_pkg::FLAG_COUNT - 1)) begin
            done_next  = 1'b1;
            ready_next = 1'b1;
            state_next = dpsf_pkg::DPSF_ST_IDLE;
          end else begin
            idx_next = idx_reg + 3'h1;
            req_next = 1'b1;
          end
        end
      end
      dpsf_pkg::DPSF_ST_IDLE: begin
        if (i_cmd_valid) begin
          ready_next = 1'b0;
          idx_next   = i_cmd_index;
          req_next   = 1'b1;
          wr_next    = 1'b1;
          polls_next = 8'h00;
          if (i_cmd_op == dpsf_pkg::DPSF_CMD_CLAIM) begin
            bit_next   = 1'b0;
            state_next = dpsf_pkg::DPSF_ST_CLAIM_WR;
          end else if (i_cmd_op == dpsf_pkg::DPSF_CMD_RELEASE) begin
            bit_next   = 1'b1;
            state_next = dpsf_pkg::DPSF_ST_RELEASE;
          end else begin
            // Any other code reruns the startup sweep from flag zero
            bit_next   = 1'b1;
            idx_next   = 3'h0;
            state_next = dpsf_pkg::DPSF_ST_INIT;
          end
        end
      end
      dpsf_pkg::DPSF_ST_CLAIM_WR: begin
        // Write then read back, never the other way round
        if (cyc.done) begin
          wr_next    = 1'b0;
          req_next   = 1'b1;
          state_next = dpsf_pkg::DPSF_ST_CLAIM_RD;
        end
      end
      dpsf_pkg::DPSF_ST_CLAIM_RD: begin
        if (cyc.done) begin
          // Flag read back as zero: the token is ours
          if (!cyc.rd_bit) begin
            grant_next          = 1'b1;
            owned_next[idx_reg] = 1'b1;
            done_next           = 1'b1;
            ready_next          = 1'b1;
            state_next          = dpsf_pkg::DPSF_ST_IDLE;
          end else if (polls_reg != dpsf_pkg::MAX_POLLS) begin
            polls_next = polls_reg + 8'h01;
            req_next   = 1'b1;
          end else begin
            // Give up: withdraw the pending request so nothing hangs
            wr_next    = 1'b1;
            bit_next   = 1'b1;
            req_next   = 1'b1;
            state_next = dpsf_pkg::DPSF_ST_WITHDRAW;
          end
        end
      end
      default: begin
        // Release or withdraw write finishing
        if (cyc.done) begin
          grant_next          = 1'b0;
          owned_next[idx_reg] = 1'b0;
          done_next           = 1'b1;
          ready_next          = 1'b1;
          state_next          = dpsf_pkg::DPSF_ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Sequencer registers; reset starts the startup sweep at once
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg <= dpsf_pkg::DPSF_ST_INIT;
      idx_reg   <= 3'h0;
      polls_reg <= 8'h00;
      req_reg   <= 1'b1;
      wr_reg    <= 1'b1;
      bit_reg   <= 1'b1;
      ready_reg <= 1'b0;
      done_reg  <= 1'b0;
      grant_reg <= 1'b0;
      owned_reg <= dpsf_pkg::OWNED_RST;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      polls_reg <= polls_next;
      req_reg   <= req_next;
      wr_reg    <= wr_next;
      bit_reg   <= bit_next;
      ready_reg <= ready_next;
      done_reg  <= done_next;
      grant_reg <= grant_next;
      owned_reg <= owned_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every port output comes straight from a register
  assign o_cmd_ready = ready_reg;
  assign o_done      = done_reg;
  assign o_granted   = grant_reg;
  assign o_owned     = owned_reg;
  assign o_ram_ce_n  = ce_n_reg;
endmodule

// file: bench/dpsf_host_ctrl_properties.sv
// Concurrent checks on the host controller pins and command port
`timescale 1ns/1ps
module dpsf_host_ctrl_properties (
  input wire logic                         i_core_clk,
  input wire logic                         i_rst,
  input wire logic                         i_cmd_valid,
  input wire logic [1:0]                   i_cmd_op,
  input wire logic                         o_cmd_ready,
  input wire logic                         o_ram_ce_n,
  input wire logic                         o_flag_space_select_n,
  input wire logic                         o_oe_n,
  input wire logic                         o_rw_n,
  input wire logic [dpsf_pkg::ADDR_W-1:0]  o_addr,
  input wire logic [dpsf_pkg::DATA_W-1:0]  o_data_out,
  input wire logic                         o_data_oe
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Access shapes on the pins
  // ----------------------------------------------------------------
  sequence wr_strobe_s;
    (!o_rw_n && !o_flag_space_select_n && o_data_oe && o_oe_n) [*4] ##1 o_rw_n;
  endsequence
  sequence rd_strobe_s;
    (!o_oe_n && !o_flag_space_select_n && o_rw_n && !o_data_oe) [*8] ##1 o_oe_n;
  endsequence
  sequence taken_s(logic [1:0] op);
    i_cmd_valid && o_cmd_ready && i_cmd_op == op;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ram_ce_idle_a: assert property (o_ram_ce_n)
    else $error("RAM chip enable went active");
  addr_high_zero_a: assert property (!o_flag_space_select_n |->
    o_addr[dpsf_pkg::ADDR_W-1:dpsf_pkg::INDEX_W] == '0)
    else $error("Upper address bits not zero in flag access");
  data_all_same_a: assert property (o_data_oe |-> (o_data_out == '0 || o_data_out == '1))
    else $error("Write data not one bit replicated");
  no_contention_a: assert property (!o_rw_n |-> o_oe_n)
    else $error("Output enable low during write");
  write_strobe_a: assert property ($fell(o_rw_n) |-> wr_strobe_s)
    else $error("Write strobe shape wrong");
  read_strobe_a: assert property ($fell(o_oe_n) |-> rd_strobe_s)
    else $error("Read strobe shape wrong");
  poll_gap_a: assert property ($rose(o_flag_space_select_n) |->
    (o_flag_space_select_n && o_oe_n) [*2])
    else $error("Select gap between accesses too short");
  claim_order_a: assert property (taken_s(2'b00) |-> ##[1:8]
    ($fell(o_rw_n) && o_data_out == '0) ##[4:14] $fell(o_oe_n))
    else $error("Claim not a zero write followed by a read");
  release_one_a: assert property (taken_s(2'b01) |-> ##[1:8]
    ($fell(o_rw_n) && o_data_out == '1))
    else $error("Release did not write one");
endmodule

bind dpsf_host_ctrl dpsf_host_ctrl_properties chk_u (.i_core_clk, .i_rst, .i_cmd_valid,
  .i_cmd_op, .o_cmd_ready, .o_ram_ce_n, .o_flag_space_select_n, .o_oe_n, .o_rw_n,
  .o_addr, .o_data_out, .o_data_oe);

// file: bench/dpsf_dev_model.sv
// Behavioural two-port semaphore flag device; left port on pins, right port by bench
`timescale 1ns/1ps
module dpsf_dev_model (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_sel_n,
  input  wire logic                        i_oe_n,
  input  wire logic                        i_rw_n,
  input  wire logic [dpsf_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [dpsf_pkg::DATA_W-1:0] i_data,
  input  wire logic                        i_r_wr,
  input  wire logic [2:0]                  i_r_index,
  input  wire logic                        i_r_bit,
  output logic [dpsf_pkg::DATA_W-1:0]      o_data,
  output logic [7:0]                       o_l_flag,
  output logic [7:0]                       o_r_flag,
  output logic [7:0]                       o_l_req
);
  // Eight latch pairs, no reset input and no power-up clear
  logic [7:0]  req_l_reg = 8'h00;
  logic [7:0]  req_r_reg = 8'hFF;
  logic [7:0]  own_l_reg = 8'hFF;
  logic [7:0]  own_r_reg = 8'h00;
  logic        rd_reg    = 1'b1;
  logic        act_reg   = 1'b0;
  logic [15:0] last_reg  = 16'h0000;
  wire         act       = !i_sel_n && !i_oe_n;

  // Mid-cycle update keeps clear of the controller's sampling edge
  always @(negedge i_core_clk) begin
    if (!i_sel_n && !i_rw_n) begin
      req_l_reg[i_addr[2:0]] = i_data[0];
    end
    if (i_r_wr) begin
      req_r_reg[i_r_index] = i_r_bit;
    end
    // Arbitration: free flag goes to first zero, left wins a tie
    for (int i = 0; i < 8; i++) begin
      if (!own_l_reg[i] && !own_r_reg[i]) begin
        own_l_reg[i] = !req_l_reg[i];
        own_r_reg[i] = req_l_reg[i] && !req_r_reg[i];
      end else if (own_l_reg[i] && req_l_reg[i]) begin
        own_l_reg[i] = 1'b0;
        own_r_reg[i] = !req_r_reg[i];
      end else if (own_r_reg[i] && req_r_reg[i]) begin
        own_r_reg[i] = 1'b0;
        own_l_reg[i] = !req_l_reg[i];
      end
    end
    // Read value frozen while select and output enable stay active
    if (act && !act_reg) begin
      rd_reg = !own_l_reg[i_addr[2:0]];
    end
    act_reg = act;
    if (act) begin
      last_reg = {16{rd_reg}};
    end
  end

  // Replicated flag while read; released bus shows inverse of last value
  assign o_data   = act ? {16{rd_reg}} : ~last_reg;
  assign o_l_flag = ~own_l_reg;
  assign o_r_flag = ~own_r_reg;
  assign o_l_req  = req_l_reg;
endmodule

// file: bench/tb_dpsf_host_ctrl.sv
// Self-checking bench for the semaphore flag host controller
`timescale 1ns/1ps
module tb_dpsf_host_ctrl;
  logic        i_core_clk = 1'b0;
  logic        i_rst      = 1'b1;
  logic        cmd_valid  = 1'b0;
  logic [1:0]  cmd_op     = 2'b00;
  logic [2:0]  cmd_index  = 3'b000;
  logic        r_wr       = 1'b0;
  logic [2:0]  r_index    = 3'b000;
  logic        r_bit      = 1'b1;
  logic        cmd_ready, done, granted, ram_ce_n, sel_n, oe_n, rw_n, data_oe;
  logic [7:0]  owned, l_flag, r_flag, l_req, own_exp;
  logic [11:0] addr;
  logic [15:0] dout, din;
  logic [2:0]  a;
  int          fail_count = 0;
  int          checks     = 0;
  int          seed       = 48722;

  dpsf_host_ctrl dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_cmd_index(cmd_index), .o_cmd_ready(cmd_ready), .o_done(done),
    .o_granted(granted), .o_owned(owned), .o_ram_ce_n(ram_ce_n),
    .o_flag_space_select_n(sel_n), .o_oe_n(oe_n), .o_rw_n(rw_n), .o_addr(addr),
    .o_data_out(dout), .o_data_oe(data_oe), .i_data_in(din));
  dpsf_dev_model dev_u (.i_core_clk(i_core_clk), .i_sel_n(sel_n), .i_oe_n(oe_n),
    .i_rw_n(rw_n), .i_addr(addr), .i_data(dout), .i_r_wr(r_wr), .i_r_index(r_index),
    .i_r_bit(r_bit), .o_data(din), .o_l_flag(l_flag), .o_r_flag(r_flag), .o_l_req(l_req));

  // Clock and watchdog
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] onehot(input logic [2:0] idx);
    return 8'h01 << idx;
  endfunction
  task automatic end_sim();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(negedge i_core_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 400);
    if (done !== 1'b1) begin
      fail_count++;
      end_sim();
    end
  endtask
  // Command presented at the next edge without waiting for ready, held for one edge
  task automatic cmd(input logic [1:0] op, input logic [2:0] idx);
    @(posedge i_core_clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_index <= idx;
    @(posedge i_core_clk);
    cmd_valid <= 1'b0;
    wait_done();
  endtask
  // Right-port write to one flag
  task automatic rwr(input logic [2:0] idx, input logic b);
    @(posedge i_core_clk);
    r_wr    <= 1'b1;
    r_index <= idx;
    r_bit   <= b;
    @(posedge i_core_clk);
    r_wr    <= 1'b0;
    @(negedge i_core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    wait_done();
    chk("ready", 8'h01, cmd_ready);
    chk("owned", 8'h00, owned);
    chk("left req", 8'hFF, l_req);
    for (int i = 0; i < 8; i++) begin
      rwr(3'(i), 1'b1);
    end
    a = 3'($random(seed));
    cmd(dpsf_pkg::DPSF_CMD_CLAIM, a);
    chk("granted", 8'h01, granted);
    chk("owned", onehot(a), owned);
    chk("left flag", ~onehot(a), l_flag);
    rwr(a, 1'b0);
    chk("right flag", 8'hFF, r_flag);
    cmd(dpsf_pkg::DPSF_CMD_RELEASE, a);
    chk("granted", 8'h00, granted);
    chk("owned", 8'h00, owned);
    chk("right flag", ~onehot(a), r_flag);
    cmd(dpsf_pkg::DPSF_CMD_CLAIM, a);
    chk("granted", 8'h00, granted);
    chk("owned", 8'h00, owned);
    chk("left req", 8'hFF, l_req);
    chk("right flag", ~onehot(a), r_flag);
    rwr(a, 1'b1);
    // Edge indexes first, then random claims and releases
    cmd(dpsf_pkg::DPSF_CMD_CLAIM, 3'h7);
    cmd(dpsf_pkg::DPSF_CMD_CLAIM, 3'h0);
    own_exp = 8'h81;
    chk("owned", own_exp, owned);
    for (int i = 0; i < 14; i++) begin
      a = 3'($random(seed));
      if ($random(seed) & 1) begin
        cmd(dpsf_pkg::DPSF_CMD_CLAIM, a);
        own_exp[a] = 1'b1;
        chk("granted", 8'h01, granted);
      end else begin
        cmd(dpsf_pkg::DPSF_CMD_RELEASE, a);
        own_exp[a] = 1'b0;
      end
      chk("owned", own_exp, owned);
      chk("left flag", ~own_exp, l_flag);
    end
    // Both init encodings free every flag
    for (int i = 2; i < 4; i++) begin
      cmd(2'(i), a);
      chk("left req", 8'hFF, l_req);
      chk("left flag", 8'hFF, l_flag);
    end
    end_sim();
  end
endmodule
